// *** design/mpy_regs.svh ***
// Functional notes
// - Four separate clocks load the two operand registers and the two product-half registers on their own rising edges, signed selects included.
// - The rounding request is registered on the rising edge of the OR of the two operand clocks.
// - Each operand is signed or unsigned by its own select, and mixed products come out in two's complement.
// - The same binary operation is done whether operands are integer or fractional.
// - With result shift inactive the upper half is doubled and the lower half's top bit repeats the product sign bit.
// - While output bypass is high the product registers follow the product without a product clock edge.
// - A high rounding request adds one at the top bit of the lower half, position 14 or 15 by result shift, always upward.
// - Each product half is driven while its output disable is low and released while it is high.
// - Multiplier data shares the lower half lines and is only presented while the lower half is disabled.
`ifndef MPY_REGS_SVH
`define MPY_REGS_SVH
// Register byte addresses
`define MPY_CTRL_ADR 8'h00
`define MPY_PROD_ADR 8'h04
`define MPY_OPER_ADR 8'h08
// Control field positions
`define MPY_CTRL_SHIFT 0
`define MPY_CTRL_BYP 1
`define MPY_CTRL_UDIS 2
`define MPY_CTRL_LDIS 3
`define MPY_CTRL_W 4
// Control reset value: both halves released
`define MPY_CTRL_RST 4'hC
// Rounding increments
`define MPY_ROUND_LO 32'h0000_4000
`define MPY_ROUND_HI 32'h0000_8000
// Clock bit positions in the synchronised clock group
`define MPY_CK_X 0
`define MPY_CK_Y 1
`define MPY_CK_L 2
`define MPY_CK_M 3
`endif

// *** design/mpy_pkg.sv ***
package mpy_pkg;
    typedef logic [15:0] mpy_word_t;
    typedef logic [31:0] mpy_prod_t;
    typedef logic signed [16:0] mpy_ext_t;
endpackage : mpy_pkg

// *** design/mpy_sync_edge.sv ***
`timescale 1ns/1ps
module mpy_sync_edge #(
    parameter int W = 1
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // Two-stage synchroniser plus edge history
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Level and rising edge from settled stages
    assign level_o = s2_reg;
    assign rise_o = s2_reg & ~s3_reg;
endmodule : mpy_sync_edge

// *** design/mpy_mult.sv ***
`timescale 1ns/1ps
`include "mpy_regs.svh"
module mpy_mult
    import mpy_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic multiplicand_clk_i,
    input wire logic multiplier_clk_i,
    input wire logic lower_clk_i,
    input wire logic upper_clk_i,
    input wire logic [15:0] multiplicand_i,
    input wire logic [15:0] multiplier_i,
    input wire logic multiplicand_signed_sel_i,
    input wire logic multiplier_signed_sel_i,
    input wire logic round_request_i,
    output logic [15:0] upper_product_half_o,
    output logic upper_product_half_oe_o,
    output logic [15:0] lower_product_half_o,
    output logic lower_product_half_oe_o
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    logic [3:0] ck_level;
    logic [3:0] ck_rise;
    logic [34:0] din_level;
    mpy_word_t x_sync;
    mpy_word_t y_sync;
    logic xs_sync;
    logic ys_sync;
    logic round_sync;

    // Clock pins with edge detection
    mpy_sync_edge #(.W(4)) u_ck_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .async_i({upper_clk_i, lower_clk_i, multiplier_clk_i, multiplicand_clk_i}),
        .level_o(ck_level),
        .rise_o(ck_rise)
    );

    // Data and mode pins, same latency as the clocks
    mpy_sync_edge #(.W(35)) u_din_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .async_i({round_request_i, multiplier_signed_sel_i, multiplicand_signed_sel_i,
                  multiplier_i, multiplicand_i}),
        .level_o(din_level),
        .rise_o()
    );

    assign x_sync = din_level[15:0];
    assign y_sync = din_level[31:16];
    assign xs_sync = din_level[32];
    assign ys_sync = din_level[33];
    assign round_sync = din_level[34];

    ////////////////////////////////////////////////////////////////////////
    // Operand registers
    mpy_word_t opx_reg;
    mpy_word_t opy_reg;
    logic xs_reg;
    logic ys_reg;
    logic round_reg;
    logic orck_prev_reg;
    logic orck_now;
    logic orck_rise;

    // Multiplicand register with its signed select
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            opx_reg <= '0;
            xs_reg <= 1'b0;
        end else if (ck_rise[`MPY_CK_X]) begin
            opx_reg <= x_sync;
            xs_reg <= xs_sync;
        end
    end

    // Multiplier register; lines shared with the lower half
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            opy_reg <= '0;
            ys_reg <= 1'b0;
        end else if (ck_rise[`MPY_CK_Y]) begin
            opy_reg <= y_sync;
            ys_reg <= ys_sync;
        end
    end

    // Combined operand clock loads the rounding request
    assign orck_now = ck_level[`MPY_CK_X] | ck_level[`MPY_CK_Y];
    assign orck_rise = orck_now & ~orck_prev_reg;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            orck_prev_reg <= 1'b0;
            round_reg <= 1'b0;
        end else begin
            orck_prev_reg <= orck_now;
            if (orck_rise) begin
                round_reg <= round_sync;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register
    logic [`MPY_CTRL_W-1:0] ctrl_reg;
    logic [`MPY_CTRL_W-1:0] ctrl_next;
    logic wb_req;
    logic result_shift_ctl;
    logic bypass;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign result_shift_ctl = ctrl_reg[`MPY_CTRL_SHIFT];
    assign bypass = ctrl_reg[`MPY_CTRL_BYP];

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `MPY_CTRL_ADR) begin
            ctrl_next = wb_dat_i[`MPY_CTRL_W-1:0];
        end
    end

    // Control bits and the output enables that follow them
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ctrl_reg <= `MPY_CTRL_RST;
            upper_product_half_oe_o <= 1'b0;
            lower_product_half_oe_o <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            upper_product_half_oe_o <= ~ctrl_next[`MPY_CTRL_UDIS];
            lower_product_half_oe_o <= ~ctrl_next[`MPY_CTRL_LDIS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Product datapath
    mpy_ext_t ext_x;
    mpy_ext_t ext_y;
    logic signed [33:0] prod_full;
    mpy_prod_t prod_raw;
    mpy_prod_t prod_sum;
    mpy_word_t fmt_upper;
    mpy_word_t fmt_lower;

    // Per-operand sign extension, one plain binary multiply
    assign ext_x = {xs_reg & opx_reg[15], opx_reg};
    assign ext_y = {ys_reg & opy_reg[15], opy_reg};
    assign prod_full = ext_x * ext_y;
    assign prod_raw = prod_full[31:0];
    // Upward rounding at the lower half's top bit
    assign prod_sum = prod_raw + (round_reg ? (result_shift_ctl ? `MPY_ROUND_HI : `MPY_ROUND_LO) : '0);
    // Shift on: full word; shift off: sign duplicated into lower top bit
    assign fmt_upper = result_shift_ctl ? prod_sum[31:16] : prod_sum[30:15];
    assign fmt_lower = result_shift_ctl ? prod_sum[15:0] : {prod_sum[31], prod_sum[14:0]};

    // Upper product register, transparent under bypass
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            upper_product_half_o <= '0;
        end else if (ck_rise[`MPY_CK_M] || bypass) begin
            upper_product_half_o <= fmt_upper;
        end
    end

    // Lower product register, transparent under bypass
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            lower_product_half_o <= '0;
        end else if (ck_rise[`MPY_CK_L] || bypass) begin
            lower_product_half_o <= fmt_lower;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one-cycle registered answer
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `MPY_CTRL_ADR: wb_dat_o <= {{(32-`MPY_CTRL_W){1'b0}}, ctrl_reg};
                    `MPY_PROD_ADR: wb_dat_o <= {upper_product_half_o, lower_product_half_o};
                    `MPY_OPER_ADR: wb_dat_o <= {opy_reg, opx_reg};
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_x_capture: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ck_rise[`MPY_CK_X] |=> (opx_reg == $past(x_sync)) && (xs_reg == $past(xs_sync)))
        else $error("multiplicand not captured on its clock");

    a_y_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !ck_rise[`MPY_CK_Y] |=> $stable(opy_reg) && $stable(ys_reg))
        else $error("multiplier changed without its clock");

    a_round_load: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (ck_rise[`MPY_CK_X] && !$past(ck_level[`MPY_CK_Y])) |=> round_reg == $past(round_sync))
        else $error("rounding request not loaded on combined clock");

    a_round_stable: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !orck_rise |=> $stable(round_reg))
        else $error("rounding request changed without combined clock edge");

    a_mixed_sign: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (xs_reg && !ys_reg && opx_reg[15] && opy_reg != '0) |-> prod_raw[31])
        else $error("mixed mode product not negative");

    a_shift_top: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (xs_reg && ys_reg && opx_reg == 16'h8000 && opy_reg == 16'h8000 && result_shift_ctl && !round_reg)
        |-> {fmt_upper, fmt_lower} == 32'h4000_0000)
        else $error("most negative square not represented with shift");

    a_round_add: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (round_reg && !result_shift_ctl) |-> prod_sum == prod_raw + `MPY_ROUND_LO)
        else $error("rounding increment wrong");

    a_bypass_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        bypass |=> (upper_product_half_o == $past(fmt_upper)) && (lower_product_half_o == $past(fmt_lower)))
        else $error("bypass did not pass product through");

    a_upper_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (!ck_rise[`MPY_CK_M] && !bypass) |=> $stable(upper_product_half_o))
        else $error("upper half changed without its clock");

    a_lower_enable: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        lower_product_half_oe_o == !ctrl_reg[`MPY_CTRL_LDIS])
        else $error("lower half enable disagrees with disable bit");

    a_wb_ack: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");
endmodule : mpy_mult

// *** tb/mpy_far_model.sv ***
`timescale 1ns/1ps
module mpy_far_model
    import mpy_pkg::*;
(
    input wire logic mclk_i,
    input wire logic lower_oe_i,
    input wire logic [15:0] lower_half_i,
    output logic [3:0] pin_clk_o,
    output mpy_word_t x_o,
    output mpy_word_t y_o,
    output logic [1:0] sel_o,
    output logic round_o
);
    mpy_word_t y_drv;
    ////////////////////////////////////////////////////////////////
    // Shared lower lines show the device while it drives them
    assign y_o = lower_oe_i ? lower_half_i : y_drv;
    // Quiet pins at time zero, clocks idle low
    initial begin
        pin_clk_o = 4'h0;
        x_o = 16'h0000;
        y_drv = 16'h0000;
        sel_o = 2'b00;
        round_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // One pin clock pulse, long enough to be seen, back to low
    task strobe(input int k);
        pin_clk_o[k] <= 1'b1;
        repeat (4) @(posedge mclk_i);
        pin_clk_o[k] <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask : strobe
    // Operands in (multiplicand clocked only if lx), then product registers clocked only if lp
    task mul(input logic lx, input logic lp, input mpy_word_t x, input mpy_word_t y,
             input logic [1:0] s, input logic r);
        x_o <= x;
        y_drv <= y;
        sel_o <= s;
        round_o <= r;
        repeat (3) @(posedge mclk_i);
        if (lx) begin
            strobe(0);
        end
        strobe(1);
        if (lp) begin
            strobe(2);
            strobe(3);
        end
    endtask : mul
endmodule : mpy_far_model

// *** tb/mpy_mult_tb.sv ***
`timescale 1ns/1ps
module mpy_mult_tb;
    import mpy_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [3:0] pclk;
    logic [1:0] ssel;
    logic round_pin;
    logic loe;
    logic moe;
    mpy_word_t xd, yd, up, lo, yv;
    logic [1:0] s_b;
    logic r_b;
    logic shift_b;
    logic [31:0] q;
    int failures = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////
    // Clock and instances
    always #12.5 mclk = ~mclk;
    mpy_far_model far_u (.mclk_i(mclk), .lower_oe_i(loe), .lower_half_i(lo), .pin_clk_o(pclk),
        .x_o(xd), .y_o(yd), .sel_o(ssel), .round_o(round_pin));
    mpy_mult dut_u (.mclk_i(mclk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .multiplicand_clk_i(pclk[0]), .multiplier_clk_i(pclk[1]), .lower_clk_i(pclk[2]),
        .upper_clk_i(pclk[3]), .multiplicand_i(xd), .multiplier_i(yd),
        .multiplicand_signed_sel_i(ssel[0]), .multiplier_signed_sel_i(ssel[1]),
        .round_request_i(round_pin), .upper_product_half_o(up), .upper_product_half_oe_o(moe),
        .lower_product_half_o(lo), .lower_product_half_oe_o(loe));
    ////////////////////////////////////////////////////////////////
    // Classic single bus cycle, held until ack
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        while (ack !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 40) begin
            failures++;
            $display("Error bus ack expected 1 got %b", ack);
        end
        @(posedge mclk);
    endtask : wb
    // Compare and report
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h got %h", what, exp, got);
        end
    endtask : check
    // Formatted product halves, upper then lower
    function automatic logic [31:0] expect_prod(input mpy_word_t x, input mpy_word_t y,
                                                input logic [1:0] s, input logic shift, input logic r);
        logic signed [33:0] p;
        logic [31:0] raw;
        p = $signed({s[0] & x[15], x}) * $signed({s[1] & y[15], y});
        raw = p[31:0] + (r ? (shift ? 32'h0000_8000 : 32'h0000_4000) : 32'h0000_0000);
        return shift ? raw : {raw[30:15], raw[31], raw[14:0]};
    endfunction : expect_prod
    // Verdict
    task summarize;
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        wb(1'b0, 8'h00, 32'h0, q);
        check("ctrl reset", 32'h0000_000C, q);
        check("oe reset", 32'h0, {30'h0, moe, loe});
        wb(1'b0, 8'h0C, 32'h0, q);
        check("unmapped read", 32'h0, q);
        // Every select pair, round on and off, most negative corner
        for (int i = 0; i < 8; i++) begin
            s_b = i[1:0];
            r_b = i[2];
            shift_b = ~(s_b[0] & s_b[1]) | r_b;
            yv = 16'h8000 | 16'(i);
            wb(1'b1, 8'h00, {28'h0, 3'b110, shift_b}, q);
            far_u.mul(1'b1, 1'b1, 16'h8000, yv, s_b, r_b);
            wb(1'b0, 8'h04, 32'h0, q);
            check("product", expect_prod(16'h8000, yv, s_b, shift_b, r_b), q);
        end
        wb(1'b0, 8'h08, 32'h0, q);
        check("operands", {yv, 16'h8000}, q);
        // Constant held, only the other operand reloaded
        far_u.mul(1'b0, 1'b1, 16'h1234, 16'h0003, 2'b11, 1'b0);
        wb(1'b0, 8'h04, 32'h0, q);
        check("constant product", expect_prod(16'h8000, 16'h0003, 2'b11, 1'b1, 1'b0), q);
        // Bypass: no product clock at all
        wb(1'b1, 8'h00, 32'h0000_000E, q);
        far_u.mul(1'b0, 1'b0, 16'h8000, 16'h0005, 2'b11, 1'b1);
        repeat (3) @(posedge mclk);
        wb(1'b0, 8'h04, 32'h0, q);
        check("bypass product", expect_prod(16'h8000, 16'h0005, 2'b11, 1'b0, 1'b1), q);
        // Halves driven onto the pins
        wb(1'b1, 8'h00, 32'h0000_000D, q);
        far_u.mul(1'b0, 1'b1, 16'h8000, 16'h0005, 2'b11, 1'b1);
        wb(1'b1, 8'h00, 32'h0000_0001, q);
        check("pin oe", 32'h3, {30'h0, moe, loe});
        check("pin product", expect_prod(16'h8000, 16'h0005, 2'b11, 1'b1, 1'b1), {up, lo});
        // Most negative square only fits with the shift on
        wb(1'b1, 8'h00, 32'h0000_000D, q);
        far_u.mul(1'b1, 1'b1, 16'h8000, 16'h8000, 2'b11, 1'b0);
        wb(1'b0, 8'h04, 32'h0, q);
        check("square product", 32'h4000_0000, q);
        // Writes to read-only and unmapped offsets leave control alone
        wb(1'b1, 8'h04, 32'h0000_0000, q);
        wb(1'b1, 8'h0C, 32'h0000_0000, q);
        wb(1'b0, 8'h00, 32'h0, q);
        check("ctrl after refused writes", 32'h0000_000D, q);
        summarize();
    end
endmodule : mpy_mult_tb
